/* include/blc_pkg.sv */
// Constants, types and state encodings shared by the block list checker.
// Function
// - Data blocks are 16 bytes, chosen by number.
// - Nonzero access mode bits 6..4 are rejected.
// - Mode byte bits 7..3 must be zero.
// - Mode 000 plaintext, 010 private, 011 family.
// - Mode values 001, 1xx are reserved errors.
// - Read allows at most 15 blocks.
// - Write allows 12 blocks, 11 above 8 services.
// - Encrypted lists spend two parameter blocks.
// - Plaintext lists access every block number.
// - Encrypted lists skip the final two entries.
// - Encrypted block numbers must ascend.
// - Ascending wraps from 0xff to 0x00.
// - All elements share one mode setting.
// - Plaintext blocks are all payload.
// - Encrypted: first IV, last MAC, rest payload.
// - Status 00 00 normal, else ff and code.
// - Bad service count answers 0xa1.
// - Bad block count answers 0xa2.
// - Unequal service entries answer 0xa3.
// - Element faults answer 0xa5.
// - Forbidden region access answers 0x60.
// - Read service count lies within 1..15.
// - Listed services must all be identical.
package blc_pkg;
    // Register byte offsets on the AXI4-Lite port.
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_SVC = 8'h04;
    localparam logic [7:0] OFS_ELEM = 8'h08;
    localparam logic [7:0] OFS_RO_MASK = 8'h0c;
    localparam logic [7:0] OFS_ENC_MASK = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_ROLE = 8'h18;
    localparam logic [7:0] OFS_INFO = 8'h1c;
    // Control register bit positions.
    localparam int CTRL_START = 0;
    localparam int CTRL_WRITE = 1;
    localparam int CTRL_THREE = 2;
    localparam int CTRL_UNMNT = 3;
    localparam int CTRL_CLEAR = 4;
    // Limits on the list sizes.
    localparam logic [4:0] LIST_DEPTH = 5'h0f;
    localparam logic [4:0] READ_MAX_SVC = 5'h0f;
    localparam logic [4:0] WRITE_MAX_SVC = 5'h0b;
    localparam logic [4:0] WRITE_WIDE_SVC = 5'h08;
    localparam logic [4:0] READ_MAX_BLK = 5'h0f;
    localparam logic [4:0] WRITE_MAX_BLK = 5'h0c;
    localparam logic [4:0] WRITE_WIDE_BLK = 5'h0b;
    localparam logic [4:0] ENC_PARAM_BLK = 5'h02;
    localparam logic [7:0] NVM_BLOCKS = 8'h20;
    localparam int BLOCK_BYTES = 16;
    // Status flag byte values.
    localparam logic [7:0] FLAG_OK = 8'h00;
    localparam logic [7:0] FLAG_ERR = 8'hff;
    localparam logic [7:0] CODE_UNMNT_RD = 8'h50;
    localparam logic [7:0] CODE_UNMNT_WR = 8'h51;
    localparam logic [7:0] CODE_SVC_CNT = 8'ha1;
    localparam logic [7:0] CODE_BLK_CNT = 8'ha2;
    localparam logic [7:0] CODE_SVC_DIFF = 8'ha3;
    localparam logic [7:0] CODE_BLK_SPEC = 8'ha5;
    localparam logic [7:0] CODE_SELF_DIAG = 8'h60;
    // Encryption kind taken from the mode field.
    typedef enum logic [1:0] {ENC_PLAIN, ENC_PRIVATE, ENC_FAMILY} blc_enc_type;
    // Role of one block of transferred data.
    typedef enum logic [1:0] {ROLE_PAYLOAD, ROLE_IV, ROLE_MAC, ROLE_NONE} blc_role_type;
    // Checker sequencing states.
    typedef enum logic [1:0] {S_IDLE, S_SCAN, S_FINISH} blc_state_type;
endpackage

/* include/blc_elem_if.sv */
// Interface carrying one block element and its decoded fields.
`timescale 1ns/1ps
interface blc_elem_if;
    import blc_pkg::*;
    logic [7:0] element_control_byte; // Access mode in bits 6..4.
    logic [7:0] element_mode_byte; // Mode byte of a 3-byte element.
    logic three_byte; // High when elements carry a mode byte.
    logic access_bad; // Access mode is not all zero.
    logic mode_bad; // Mode byte is reserved or has stray bits.
    blc_enc_type enc_kind; // Decoded encryption kind.
    modport dec
    (
        input element_control_byte, element_mode_byte, three_byte,
        output access_bad, mode_bad, enc_kind
    );
    modport user
    (
        output element_control_byte, element_mode_byte, three_byte,
        input access_bad, mode_bad, enc_kind
    );
endinterface

/* rtl/blc_elem_decoder.sv */
// Combinational decoder for the control and mode bytes of a block element.
`timescale 1ns/1ps
module blc_elem_decoder
    import blc_pkg::*;
(
    blc_elem_if.dec elem
);
    // A 2-byte element has no mode byte, so it always reads as plaintext.
    logic [7:0] mode;
    assign mode = elem.three_byte ? elem.element_mode_byte : 8'h00;

    // Any set access mode bit is an element fault.
    assign elem.access_bad = |elem.element_control_byte[6:4];

    // Upper mode bits must be clear and only three codes are defined.
    always_comb
    begin
        elem.mode_bad = |mode[7:3];
        elem.enc_kind = ENC_PLAIN;
        unique case (mode[2:0])
            3'h0: elem.enc_kind = ENC_PLAIN;
            3'h2: elem.enc_kind = ENC_PRIVATE;
            3'h3: elem.enc_kind = ENC_FAMILY;
            default:
            begin
                // Reserved codes flag an error; the kind stays plaintext.
                elem.mode_bad = 1'b1;
            end
        endcase
    end
endmodule

/* rtl/blc_status_enc.sv */
// Priority encoder that turns error conditions into two status flag bytes.
`timescale 1ns/1ps
module blc_status_enc
    import blc_pkg::*;
(
    input wire logic unmounted,
    input wire logic is_write,
    input wire logic err_svc_cnt,
    input wire logic err_svc_diff,
    input wire logic err_blk_cnt,
    input wire logic err_blk_spec,
    input wire logic err_self_diag,
    output logic [7:0] flag1,
    output logic [7:0] flag2
);
    // Exactly one code wins; counts are checked before element contents,
    // since element faults mean little once the list size is wrong.
    always_comb
    begin
        flag1 = FLAG_ERR;
        if (unmounted)
            flag2 = is_write ? CODE_UNMNT_WR : CODE_UNMNT_RD;
        else if (err_svc_cnt)
            flag2 = CODE_SVC_CNT;
        else if (err_svc_diff)
            flag2 = CODE_SVC_DIFF;
        else if (err_blk_cnt)
            flag2 = CODE_BLK_CNT;
        else if (err_blk_spec)
            flag2 = CODE_BLK_SPEC;
        else if (err_self_diag)
            flag2 = CODE_SELF_DIAG;
        else
        begin
            // Normal end clears both bytes.
            flag1 = FLAG_OK;
            flag2 = FLAG_OK;
        end
    end
endmodule

/* rtl/blc_block_list_checker.sv */
// Block list checker: AXI4-Lite register file, element scan and status.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module blc_block_list_checker
    import blc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // Write channel holding registers; address and data may come apart.
    logic aw_hold;
    logic w_hold;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire; // Both halves present and response slot free.
    // Configuration written by software.
    logic is_write;
    logic three_byte;
    logic unmounted;
    logic [31:0] ro_mask; // Read-only blocks, one bit per block.
    logic [31:0] enc_mask; // Blocks open to encrypted access only.
    logic [3:0] role_idx; // Block index whose role is read back.
    // Service and block lists.
    logic [4:0] svc_cnt; // Saturates so that overlong lists stay visible.
    logic [15:0] svc_first;
    logic svc_diff;
    logic [4:0] blk_cnt;
    logic [23:0] elem_mem [0:14]; // Stored elements, low byte is control.
    // Scan state.
    blc_state_type state;
    logic [3:0] idx;
    logic [7:0] prev_num;
    blc_enc_type kind_first;
    logic enc_on;
    logic err_spec;
    logic err_diag;
    logic busy;
    logic done;
    logic [7:0] flag1;
    logic [7:0] flag2;
    // Combinational scan terms.
    logic [23:0] cur;
    logic cur_enc;
    logic accessed;
    logic asc_ok;
    logic enc_now;
    logic err_svc;
    logic err_blk;
    logic [7:0] next_flag1;
    logic [7:0] next_flag2;
    logic start;
    logic [31:0] wmerge;

    blc_elem_if elem ();

    // Merge strobed bytes into an old value.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
        input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
                r[8*b +: 8] = nw[8*b +: 8];
        end
        return r;
    endfunction

    // Block count limit for the command and service count.
    function automatic logic [4:0] blk_limit(input logic wr, input logic [4:0] svc);
        if (!wr)
            return READ_MAX_BLK;
        return (svc > WRITE_WIDE_SVC) ? WRITE_WIDE_BLK : WRITE_MAX_BLK;
    endfunction

    // Role of the data block at index k in a list of m blocks.
    function automatic blc_role_type block_role(input logic [3:0] k, input logic [4:0] m,
        input logic enc);
        if ({1'b0, k} >= m)
            return ROLE_NONE;
        if (!enc)
            return ROLE_PAYLOAD;
        if (k == 4'h0)
            return ROLE_IV;
        if ({1'b0, k} == m - 5'h01)
            return ROLE_MAC;
        return ROLE_PAYLOAD;
    endfunction

    // Ready signals drop while the clock enable freezes the block.
    assign s_axi_awready = ce && !aw_hold && !s_axi_bvalid;
    assign s_axi_wready = ce && !w_hold && !s_axi_bvalid;
    assign s_axi_arready = ce && !s_axi_rvalid;
    assign wr_fire = ce && aw_hold && w_hold && !s_axi_bvalid;
    assign wmerge = merge(32'h0000_0000, w_data, w_strb);
    assign busy = (state != S_IDLE);
    assign start = wr_fire && (aw_addr == OFS_CTRL) && wmerge[CTRL_START] && !busy;

    // Capture write address and data independently.
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end
        else if (ce)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            else if (wr_fire)
                aw_hold <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            else if (wr_fire)
                w_hold <= 1'b0;
        end
    end

    // Write response; unmapped or read-only offsets answer SLVERR.
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end
        else if (ce)
        begin
            if (wr_fire)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr <= OFS_ENC_MASK || aw_addr == OFS_ROLE) ? 2'h0 : 2'h2;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // Control, masks and role index; list pushes are ignored while busy.
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            is_write <= 1'b0;
            three_byte <= 1'b0;
            unmounted <= 1'b0;
            ro_mask <= 32'h0000_0000;
            enc_mask <= 32'h0000_0000;
            role_idx <= 4'h0;
        end
        else if (ce && wr_fire)
        begin
            if (aw_addr == OFS_CTRL && !busy && w_strb[0])
            begin
                is_write <= w_data[CTRL_WRITE];
                three_byte <= w_data[CTRL_THREE];
                unmounted <= w_data[CTRL_UNMNT];
            end
            if (aw_addr == OFS_RO_MASK)
                ro_mask <= merge(ro_mask, w_data, w_strb);
            if (aw_addr == OFS_ENC_MASK)
                enc_mask <= merge(enc_mask, w_data, w_strb);
            if (aw_addr == OFS_ROLE && w_strb[0])
                role_idx <= w_data[3:0];
        end
    end

    // Service list: only the count and equality of entries are kept.
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            svc_cnt <= 5'h00;
            svc_first <= 16'h0000;
            svc_diff <= 1'b0;
        end
        else if (ce && wr_fire && !busy)
        begin
            if (aw_addr == OFS_CTRL && wmerge[CTRL_CLEAR])
            begin
                svc_cnt <= 5'h00;
                svc_diff <= 1'b0;
            end
            else if (aw_addr == OFS_SVC)
            begin
                if (svc_cnt != 5'h1f)
                    svc_cnt <= svc_cnt + 5'h01;
                if (svc_cnt == 5'h00)
                    svc_first <= wmerge[15:0];
                else if (wmerge[15:0] != svc_first)
                    svc_diff <= 1'b1;
            end
        end
    end

    // Block list: each entry selects one 16-byte block by its number.
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
            blk_cnt <= 5'h00;
        else if (ce && wr_fire && !busy)
        begin
            if (aw_addr == OFS_CTRL && wmerge[CTRL_CLEAR])
                blk_cnt <= 5'h00;
            else if (aw_addr == OFS_ELEM && blk_cnt != 5'h1f)
                blk_cnt <= blk_cnt + 5'h01;
        end
    end

    // Element storage has no reset; entries past the count are never read.
    always_ff @(posedge ref_clk)
    begin
        if (ce && wr_fire && !busy && aw_addr == OFS_ELEM && blk_cnt < LIST_DEPTH)
            elem_mem[blk_cnt[3:0]] <= wmerge[23:0];
    end

    // Present the current element to the decoder.
    assign cur = elem_mem[idx];
    assign elem.element_control_byte = cur[7:0];
    assign elem.element_mode_byte = cur[23:16];
    assign elem.three_byte = three_byte;
    blc_elem_decoder u_dec
    (
        .elem(elem)
    );

    // The first element fixes the mode for the whole list.
    assign enc_now = (elem.enc_kind != ENC_PLAIN);
    assign cur_enc = (idx == 4'h0) ? enc_now : enc_on;
    // Encrypted lists touch only the first m-2 numbers.
    assign accessed = !cur_enc || ({1'b0, idx} + ENC_PARAM_BLK < blk_cnt);
    // Strictly rising, with 0xff followed by 0x00 allowed.
    assign asc_ok = (cur[15:8] > prev_num) || (prev_num == 8'hff && cur[15:8] == 8'h00);

    // Count checks evaluated when the scan ends.
    assign err_svc = (~|svc_cnt) || (svc_cnt > (is_write ? WRITE_MAX_SVC : READ_MAX_SVC));
    assign err_blk = (blk_cnt == 5'h00) || (blk_cnt > blk_limit(is_write, svc_cnt))
        || (enc_on && blk_cnt <= ENC_PARAM_BLK);

    blc_status_enc u_enc
    (
        .unmounted(unmounted),
        .is_write(is_write),
        .err_svc_cnt(err_svc),
        .err_svc_diff(svc_diff),
        .err_blk_cnt(err_blk),
        .err_blk_spec(err_spec),
        .err_self_diag(err_diag),
        .flag1(next_flag1),
        .flag2(next_flag2)
    );

    // Sequencer: one element per cycle, then one cycle to settle status.
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            state <= S_IDLE;
            idx <= 4'h0;
        end
        else if (ce)
        begin
            unique case (state)
                S_IDLE:
                begin
                    idx <= 4'h0;
                    if (start)
                        state <= (blk_cnt == 5'h00 || blk_cnt > LIST_DEPTH) ? S_FINISH : S_SCAN;
                end
                S_SCAN:
                begin
                    idx <= idx + 4'h1;
                    if ({1'b0, idx} == blk_cnt - 5'h01)
                        state <= S_FINISH;
                end
                S_FINISH:
                    state <= S_IDLE;
            endcase
        end
    end

    // Per-element checks accumulate while scanning.
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            err_spec <= 1'b0;
            err_diag <= 1'b0;
            enc_on <= 1'b0;
            kind_first <= ENC_PLAIN;
            prev_num <= 8'h00;
        end
        else if (ce)
        begin
            if (start)
            begin
                err_spec <= 1'b0;
                err_diag <= 1'b0;
                enc_on <= 1'b0;
            end
            else if (state == S_SCAN)
            begin
                prev_num <= cur[15:8];
                if (idx == 4'h0)
                begin
                    enc_on <= enc_now;
                    kind_first <= elem.enc_kind;
                end
                if (elem.access_bad || elem.mode_bad)
                    err_spec <= 1'b1;
                if (idx != 4'h0 && elem.enc_kind != kind_first)
                    err_spec <= 1'b1;
                if (accessed && cur[15:8] >= NVM_BLOCKS)
                    err_spec <= 1'b1;
                if (cur_enc && idx != 4'h0 && !asc_ok)
                    err_spec <= 1'b1;
                if (accessed && cur[15:8] < NVM_BLOCKS
                    && ((is_write && ro_mask[cur[12:8]]) || (!cur_enc && enc_mask[cur[12:8]])))
                    err_diag <= 1'b1;
            end
        end
    end

    // Status bytes latch at the end of a scan; done holds until next start.
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            done <= 1'b0;
            flag1 <= FLAG_OK;
            flag2 <= FLAG_OK;
        end
        else if (ce)
        begin
            if (state == S_FINISH)
            begin
                done <= 1'b1;
                flag1 <= next_flag1;
                flag2 <= next_flag2;
            end
            else if (start)
                done <= 1'b0;
        end
    end

    // Read channel with registered data.
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end
        else if (ce)
        begin
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'h0;
                unique case (s_axi_araddr)
                    OFS_CTRL: s_axi_rdata <= {28'h0, unmounted, three_byte, is_write, 1'b0};
                    OFS_RO_MASK: s_axi_rdata <= ro_mask;
                    OFS_ENC_MASK: s_axi_rdata <= enc_mask;
                    OFS_STATUS: s_axi_rdata <= {5'h0, kind_first, enc_on, flag2, flag1, 6'h0,
                        done, busy};
                    OFS_ROLE: s_axi_rdata <= {26'h0, block_role(role_idx, blk_cnt, enc_on),
                        role_idx};
                    OFS_INFO: s_axi_rdata <= {11'h0, (enc_on ? blk_cnt - ENC_PARAM_BLK : blk_cnt),
                        3'h0, blk_cnt, 3'h0, svc_cnt};
                    default:
                    begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= 2'h2;
                    end
                endcase
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // Checks on the sequencing, status encoding and element scan.
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    sequence s_launch;
        ce && start;
    endsequence
    sequence s_finish;
        ce && state == S_FINISH;
    endsequence

    a_launch_busy: assert property (s_launch |=> busy && !done)
        else $error("Start did not raise busy.");
    a_status_pair: assert property (s_finish |=> (flag1 == FLAG_OK && flag2 == FLAG_OK)
        || (flag1 == FLAG_ERR && flag2 != FLAG_OK))
        else $error("Status bytes inconsistent.");
    a_svc_range: assert property (s_finish ##0 (!unmounted && err_svc)
        |=> flag2 == CODE_SVC_CNT)
        else $error("Service count error not reported.");
    a_svc_equal: assert property (s_finish ##0 (!unmounted && !err_svc && svc_diff)
        |=> flag2 == CODE_SVC_DIFF)
        else $error("Service mismatch not reported.");
    a_blk_range: assert property (s_finish ##0 (!unmounted && !err_svc && !svc_diff
        && is_write && blk_cnt == 5'h0c && svc_cnt > 5'h08) |=> flag2 == CODE_BLK_CNT)
        else $error("Write block cap not enforced.");
    a_access_mode: assert property (ce && state == S_SCAN && elem.access_bad |=> err_spec)
        else $error("Access mode fault missed.");
    a_mode_reserved: assert property (ce && state == S_SCAN && three_byte
        && cur[18:16] == 3'h1 |=> err_spec)
        else $error("Reserved mode missed.");
    a_asc_wrap: assert property (ce && state == S_SCAN && idx != 4'h0 && prev_num == 8'hff
        && cur[15:8] == 8'h00 |-> asc_ok)
        else $error("Wrap from 0xff rejected.");
    a_dummy_skip: assert property (ce && state == S_SCAN && cur_enc
        && {1'b0, idx} + 5'h02 >= blk_cnt && !err_diag |=> !err_diag)
        else $error("Dummy entry was accessed.");
endmodule

/* verif/blc_host_model.sv */
// Software-side AXI4-Lite master that issues checker commands.
`timescale 1ns/1ps
module blc_host_model
(
    input wire logic ref_clk,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    // Idle bus at time zero; whole words are always strobed.
    initial
    begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
    end
    // One write; each half is released only at the edge that takes it.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do
        begin
            @(posedge ref_clk);
            if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
            if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
    endtask
    // One read; rready stays up until the data is seen.
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do
        begin
            @(posedge ref_clk);
            if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
    endtask
endmodule

/* verif/block_list_checker_bench.sv */
// Self-checking bench: model of the status rules against the checker.
`timescale 1ns/1ps
module block_list_checker_bench;
    import blc_pkg::*;
    logic ref_clk = 1'b0, rstn = 1'b0, ce = 1'b1;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, got, ro = '0, enc = '0;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [15:0] svc[$];
    logic [7:0] blk[$], md[$], acm[$];
    bit wr, three, unm;
    int failures = 0, checks = 0, cycles = 0;
    blc_block_list_checker dut (.*);
    blc_host_model host (.*);
    initial forever #5 ref_clk = ~ref_clk;
    // Hang guard; a full run needs about a thousand cycles.
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            final_report();
        end
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD %s exp %h got %h", nm, exp, seen);
        end
    endtask
    task automatic final_report();
        if (failures == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Expected second status byte, in the chosen priority order.
    function automatic logic [7:0] model();
        int m = blk.size();
        int k = svc.size();
        int e = three ? md[0] : 0;
        int n = (e != 0) ? m - 2 : m;
        if (unm) return wr ? 8'h51 : 8'h50;
        if (k == 0 || k > (wr ? 11 : 15)) return 8'ha1;
        foreach (svc[i]) if (svc[i] != svc[0]) return 8'ha3;
        if (m == 0 || m > (wr ? (k > 8 ? 11 : 12) : 15) || (e != 0 && m <= 2)) return 8'ha2;
        foreach (blk[i])
        begin
            if (acm[i] != 0 || (three && (md[i] != md[0] || !(md[i] inside {0, 2, 3}))))
                return 8'ha5;
            if (e != 0 && i > 0 && !(blk[i] > blk[i-1] || (blk[i-1] == 8'hff && blk[i] == 0)))
                return 8'ha5;
            if (i < n && blk[i] >= 32) return 8'ha5;
        end
        for (int i = 0; i < n; i++) if ((wr && ro[blk[i]]) || (!e && enc[blk[i]])) return 8'h60;
        return 8'h00;
    endfunction
    // Ascending list of m blocks from f, k equal random services.
    task automatic build(input bit w, t, input int k, m, input logic [7:0] f, mo);
        {wr, three} = {w, t};
        svc = {};
        blk = {};
        md = {};
        acm = {};
        got[15:0] = 16'($urandom);
        repeat (k) svc.push_back(got[15:0]);
        for (int i = 0; i < m; i++)
        begin
            blk.push_back(f + 8'(i));
            md.push_back(mo);
            acm.push_back(8'h00);
        end
    endtask
    // Load lists, start, wait for done and compare status, count and roles.
    task automatic run();
        logic [7:0] code;
        int m, e;
        code = model();
        m = blk.size();
        e = three ? md[0] : 0;
        host.wr(OFS_RO_MASK, ro, resp);
        host.wr(OFS_ENC_MASK, enc, resp);
        host.wr(OFS_CTRL, 32'h10, resp);
        foreach (svc[i]) host.wr(OFS_SVC, {16'h0, svc[i]}, resp);
        foreach (blk[i]) host.wr(OFS_ELEM, {8'h0, md[i], blk[i], acm[i] << 4}, resp);
        host.wr(OFS_CTRL, {28'h0, unm, three, wr, 1'b1}, resp);
        got = '0;
        for (int t = 0; t < 40 && !got[1]; t++) host.rd(OFS_STATUS, got);
        chk("flags", {16'h0, code, (code != 0) ? 8'hff : 8'h00}, {16'h0, got[23:8]});
        if (code != 0) return;
        chk("kind", (e == 0) ? 0 : e - 1, 32'(got[26:25]));
        host.rd(OFS_INFO, got);
        chk("accessed", (e == 0) ? m : m - 2, 32'(got[20:16]));
        for (int i = 0; i < m; i++)
        begin
            host.wr(OFS_ROLE, i, resp);
            host.rd(OFS_ROLE, got);
            chk("role", (e == 0) ? 0 : (i == 0) ? 1 : (i == m - 1) ? 2 : 0,
                32'(got[5:4]));
        end
    endtask
    initial
    begin
        void'($urandom(32'h8a024ed0));
        repeat (5) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        host.wr(8'h20, 32'h0, resp);
        host.rd(8'h20, got);
        chk("slverr", 32'h0000_000a, {got[27:0], resp, s_axi_rresp});
        build(0, 0, 15, 15, 0, 0);
        foreach (blk[i]) blk[i] = 8'($urandom_range(31));
        run();
        build(0, 1, 3, 4, 8'h1e, 2);
        blk[2] = 8'hff;
        blk[3] = 8'h00;
        run();
        build(1, 1, 1, 12, 8'h00, 3);
        run();
        build(0, 1, 1, 3, 8'h05, 2);
        blk[1] = 8'h04;
        run();
        foreach (blk[i]) md[i] = 8'h03;
        md[0] = 8'h02;
        blk[1] = 8'h06;
        run();
        foreach (md[i]) md[i] = 8'h02;
        acm[1] = 8'h04;
        run();
        for (int i = 0; i < 6; i++)
        begin
            build(0, 1, 1, 3, 8'h01, 8'(48'h01_04_05_06_07_0a >> (8 * (5 - i))));
            run();
        end
        build(1, 0, 9, 12, 0, 0);
        run();
        build(1, 0, 12, 2, 0, 0);
        run();
        build(0, 0, 2, 2, 0, 0);
        svc[1] ^= 16'h1;
        run();
        build(1, 0, 1, 2, 8'h03, 0);
        ro = 32'h10;
        run();
        enc = 32'h8;
        build(0, 0, 1, 1, 8'h03, 0);
        run();
        unm = 1'b1;
        run();
        final_report();
    end
endmodule
